// ==== common/rfc_pkg.sv ====
//
// Contract
// - Range select 0: upper value is 3072 plus 128 times low three code bits.
// - Range select 1: upper value is 128 times six-bit code; default 3840.
// - Tuning word is 13 bits: upper value plus seven-bit lower value.
// - Tuning word spans 3072..4095 in range 0, 0..8191 in range 1.
// - Clock output pin stays inactive while clock-output enable is 0.
// - Enable 1 with active flag 0 keeps clock off until a wake event.
// - Active flag self-sets on bit-check ok in RX or RX polling mode, wake pin event or wake status.
// - Enable and active flag both 1 drive the clock; both reset to 1.
// - Amplitude keying select 1 chooses ASK, 0 FSK; ignored in full duplex.
// - Poll sleep interval is count times 1024 base periods times sleep stretch.
// - Sleep stretch is 1 when its bit is 0, 8 when 1.
// - Limit stretch is 1 or 2; scales edge limits; inactive in TX, FD master.
// - Check count codes 0..3 give 0, 3, 6, 9 bits; default 3.
// - Minimum edge limit is six-bit field times bit sample period; default 11.
// - Bit sample period is 8, 4, 2 or 1 base periods times limit stretch.
package rfc_pkg;
   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [2:0] ADDR_FREQ_CLK   = 3'h2;
   localparam logic [2:0] ADDR_KEY_SLEEP  = 3'h3;
   localparam logic [2:0] ADDR_CHK_LIM    = 3'h4;
   localparam logic [7:0] RST_FREQ_CLK    = 8'h7B;
   localparam logic [7:0] RST_KEY_SLEEP   = 8'h60;
   localparam logic [7:0] RST_CHK_LIM     = 8'h4B;
   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int FREQ_MSB    = 7;
   localparam int FREQ_LSB    = 2;
   localparam int CLK_EN_BIT  = 1;
   localparam int CLK_ON_BIT  = 0;
   localparam int ASK_BIT     = 7;
   localparam int SLEEP_MSB   = 6;
   localparam int SLEEP_LSB   = 2;
   localparam int SLEEP_STRETCH_SEL_BIT  = 1;
   localparam int LIMIT_STRETCH_SEL_BIT    = 0;
   localparam int CHK_MSB     = 7;
   localparam int CHK_LSB     = 6;
   localparam int LIMMIN_MSB  = 5;
   localparam int LIMMIN_LSB  = 0;
   // ----------------------------------------
   // Arithmetic constants
   // ----------------------------------------
   localparam int          TUNE_W          = 13;
   localparam logic [12:0] RANGE0_BASE     = 13'h0C00;
   localparam logic [12:0] RANGE0_TOP      = 13'h0FFF;
   localparam int          SLEEP_UNIT_SH   = 10;
   localparam int          SLEEP_STRETCH_SEL_SH       = 3;
   localparam int          SLEEP_W         = 18;
   localparam logic [4:0]  BSP_RANGE0      = 5'h08;
   localparam int          BSP_W           = 5;
   localparam int          MINLIM_W        = 10;
   localparam logic [5:0]  MINLIM_LEAST    = 6'h0A;
   // ----------------------------------------
   // Operating mode codes
   // ----------------------------------------
   localparam logic [2:0] OPM_IDLE    = 3'h0;
   localparam logic [2:0] OPM_TX      = 3'h1;
   localparam logic [2:0] OPM_RXPOLL  = 3'h2;
   localparam logic [2:0] OPM_RX      = 3'h3;
   localparam logic [2:0] OPM_FDM     = 3'h5;
   localparam logic [2:0] OPM_FDS     = 3'h7;
endpackage

// ==== common/rfc_cfg_if.sv ====
`timescale 1ns/1ps
interface rfc_cfg_if;
   logic [5:0]  freq_code;
   logic        range_sel;
   logic [6:0]  lower;
   logic [12:0] tune_word;
   logic        clk_en;
   logic        flag_wr;
   logic        flag_wr_val;
   logic        set_evt;
   logic        flag;
   logic        clk_out;
   modport tune (input freq_code, input range_sel, input lower, output tune_word);
   modport gate (input clk_en, input flag_wr, input flag_wr_val, input set_evt, output flag, output clk_out);
   modport ctl  (output freq_code, output range_sel, output lower, input tune_word,
                 output clk_en, output flag_wr, output flag_wr_val, output set_evt, input flag, input clk_out);
endinterface

// ==== hdl/rfc_tune_calc.sv ====
`timescale 1ns/1ps
module rfc_tune_calc (
   input  wire logic clk,
   input  wire logic rst_n,
   rfc_cfg_if.tune   cfg
);
   wire logic [12:0] upper_r0;
   wire logic [12:0] upper_r1;
   wire logic [12:0] nxt_word;
   logic      [12:0] word_ff;

   assign upper_r0 = rfc_pkg::RANGE0_BASE + {3'h0, cfg.freq_code[2:0], 7'h00};
   assign upper_r1 = {cfg.freq_code, 7'h00};
   // Lower part occupies bits below the upper step, so a plain sum never carries out
   assign nxt_word = (cfg.range_sel ? upper_r1 : upper_r0) + {6'h00, cfg.lower};

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         word_ff <= 13'h0F00;
      end else begin
         word_ff <= nxt_word;
      end
   end
   assign cfg.tune_word = word_ff;

   property p_range0_limits;
      @(posedge clk) disable iff (!rst_n)
      !cfg.range_sel |=> (word_ff >= rfc_pkg::RANGE0_BASE) && (word_ff <= rfc_pkg::RANGE0_TOP);
   endproperty
   a_range0_limits: assert property (p_range0_limits) else $error("range 0 tuning word out of span");

   property p_range1_value;
      @(posedge clk) disable iff (!rst_n)
      cfg.range_sel |=> word_ff == {$past(cfg.freq_code), $past(cfg.lower)};
   endproperty
   a_range1_value: assert property (p_range1_value) else $error("range 1 tuning word wrong");
endmodule

// ==== hdl/rfc_clk_gate.sv ====
`timescale 1ns/1ps
module rfc_clk_gate (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic clk_src_in,
   rfc_cfg_if.gate   cfg
);
   logic      flag_ff;
   logic      clk_out_ff;
   wire logic nxt_flag;
   wire logic nxt_clk_out;

   // Hardware set beats a software clear in the same cycle
   assign nxt_flag    = cfg.set_evt ? 1'b1 : (cfg.flag_wr ? cfg.flag_wr_val : flag_ff);
   assign nxt_clk_out = cfg.clk_en & flag_ff & clk_src_in;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         flag_ff    <= 1'b1;
         clk_out_ff <= 1'b0;
      end else begin
         flag_ff    <= nxt_flag;
         clk_out_ff <= nxt_clk_out;
      end
   end
   assign cfg.flag    = flag_ff;
   assign cfg.clk_out = clk_out_ff;

   property p_off_when_disabled;
      @(posedge clk) disable iff (!rst_n)
      !cfg.clk_en |=> !clk_out_ff;
   endproperty
   a_off_when_disabled: assert property (p_off_when_disabled) else $error("clock pin active while disabled");

   property p_event_sets_flag;
      @(posedge clk) disable iff (!rst_n)
      cfg.set_evt |=> flag_ff;
   endproperty
   a_event_sets_flag: assert property (p_event_sets_flag) else $error("wake event lost");

   property p_held_off_until_event;
      @(posedge clk) disable iff (!rst_n)
      (!flag_ff && !cfg.set_evt && !cfg.flag_wr) |=> !flag_ff ##1 !clk_out_ff;
   endproperty
   a_held_off_until_event: assert property (p_held_off_until_event) else $error("clock started without event");

   property p_drives_when_on;
      @(posedge clk) disable iff (!rst_n)
      (cfg.clk_en && flag_ff) |=> clk_out_ff == $past(clk_src_in);
   endproperty
   a_drives_when_on: assert property (p_drives_when_on) else $error("clock not driven when on");
endmodule

// ==== hdl/rfc_cfg_regs.sv ====
`timescale 1ns/1ps
module rfc_cfg_regs (
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic        reg_wr_en,
   input  wire logic        reg_rd_en,
   input  wire logic [2:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   output logic      [7:0]  reg_rdata,
   output logic             reg_rd_hit,
   input  wire logic        pll_range_sel,
   input  wire logic [2:0]  op_mode,
   input  wire logic [6:0]  rf_tune_lower_value,
   input  wire logic [1:0]  baud_range,
   input  wire logic        bit_check_ok,
   input  wire logic        wake_pin_n,
   input  wire logic        wake_status,
   input  wire logic        clk_src_in,
   output logic      [12:0] rf_tune_word,
   output logic             clk_out,
   output logic             amplitude_keying_sel,
   output logic      [17:0] sleep_interval,
   output logic      [3:0]  check_bit_count,
   output logic      [4:0]  bit_sample_period,
   output logic      [9:0]  min_limit_period
);
   // ----------------------------------------
   // Reset release
   // ----------------------------------------
   logic rst_meta_ff;
   logic rst_sync_ff;
   wire logic rst_n;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rst_meta_ff <= 1'b0;
         rst_sync_ff <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_sync_ff <= rst_meta_ff;
      end
   end
   assign rst_n = rst_sync_ff;

   // ----------------------------------------
   // Register storage
   // ----------------------------------------
   logic [7:1] freq_clk_ff;
   logic [7:0] key_sleep_ff;
   logic [7:0] chk_lim_ff;
   wire logic  wr_freq_clk;
   wire logic  wr_key_sleep;
   wire logic  wr_chk_lim;

   assign wr_freq_clk  = reg_wr_en && (reg_addr == rfc_pkg::ADDR_FREQ_CLK);
   assign wr_key_sleep = reg_wr_en && (reg_addr == rfc_pkg::ADDR_KEY_SLEEP);
   assign wr_chk_lim   = reg_wr_en && (reg_addr == rfc_pkg::ADDR_CHK_LIM);

   // Stored fields never depend on mode, so nothing is lost across mode changes
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         freq_clk_ff  <= rfc_pkg::RST_FREQ_CLK[7:1];
         key_sleep_ff <= rfc_pkg::RST_KEY_SLEEP;
         chk_lim_ff   <= rfc_pkg::RST_CHK_LIM;
      end else begin
         if (wr_freq_clk) begin
            freq_clk_ff <= reg_wdata[7:1];
         end
         if (wr_key_sleep) begin
            key_sleep_ff <= reg_wdata;
         end
         if (wr_chk_lim) begin
            chk_lim_ff <= reg_wdata;
         end
      end
   end

   // ----------------------------------------
   // Read port
   // ----------------------------------------
   rfc_cfg_if cfg ();

   wire logic [7:0] rd_freq_clk;
   wire logic       rd_mapped;
   wire logic [7:0] nxt_rdata;
   logic      [7:0] rdata_ff;
   logic            rd_hit_ff;

   assign rd_freq_clk = {freq_clk_ff, cfg.flag};
   assign rd_mapped   = (reg_addr == rfc_pkg::ADDR_FREQ_CLK) ||
                        (reg_addr == rfc_pkg::ADDR_KEY_SLEEP) ||
                        (reg_addr == rfc_pkg::ADDR_CHK_LIM);
   // Addresses owned by neighbouring banks read as zero with no hit
   assign nxt_rdata   = (reg_addr == rfc_pkg::ADDR_FREQ_CLK)  ? rd_freq_clk :
                        (reg_addr == rfc_pkg::ADDR_KEY_SLEEP) ? key_sleep_ff :
                        (reg_addr == rfc_pkg::ADDR_CHK_LIM)   ? chk_lim_ff : 8'h00;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_ff  <= 8'h00;
         rd_hit_ff <= 1'b0;
      end else begin
         rd_hit_ff <= reg_rd_en && rd_mapped;
         if (reg_rd_en) begin
            rdata_ff <= nxt_rdata;
         end
      end
   end
   assign reg_rdata  = rdata_ff;
   assign reg_rd_hit = rd_hit_ff;

   // ----------------------------------------
   // Mode decode
   // ----------------------------------------
   wire logic mode_tx;
   wire logic mode_rx_any;
   wire logic mode_fd;
   wire logic mode_fdm;
   wire logic mode_fds;
   wire logic mode_poll;

   assign mode_tx     = op_mode == rfc_pkg::OPM_TX;
   assign mode_poll   = op_mode == rfc_pkg::OPM_RXPOLL;
   assign mode_rx_any = mode_poll || (op_mode == rfc_pkg::OPM_RX);
   assign mode_fdm    = op_mode == rfc_pkg::OPM_FDM;
   assign mode_fds    = op_mode == rfc_pkg::OPM_FDS;
   assign mode_fd     = mode_fdm || mode_fds;

   // ----------------------------------------
   // Synthesizer word and clock gate
   // ----------------------------------------
   logic      wake_prev_ff;
   wire logic wake_fall;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wake_prev_ff <= 1'b1;
      end else begin
         wake_prev_ff <= wake_pin_n;
      end
   end
   assign wake_fall = wake_prev_ff && !wake_pin_n;

   assign cfg.freq_code   = freq_clk_ff[rfc_pkg::FREQ_MSB:rfc_pkg::FREQ_LSB];
   assign cfg.range_sel   = pll_range_sel;
   assign cfg.lower       = rf_tune_lower_value;
   assign cfg.clk_en      = freq_clk_ff[rfc_pkg::CLK_EN_BIT];
   assign cfg.flag_wr     = wr_freq_clk;
   assign cfg.flag_wr_val = reg_wdata[rfc_pkg::CLK_ON_BIT];
   assign cfg.set_evt     = (bit_check_ok && mode_rx_any) || wake_fall || wake_status;

   rfc_tune_calc u_tune (
      .clk   (clk),
      .rst_n (rst_n),
      .cfg   (cfg.tune)
   );

   rfc_clk_gate u_gate (
      .clk        (clk),
      .rst_n      (rst_n),
      .clk_src_in (clk_src_in),
      .cfg        (cfg.gate)
   );

   assign rf_tune_word = cfg.tune_word;
   assign clk_out      = cfg.clk_out;

   // ----------------------------------------
   // Effective settings
   // ----------------------------------------
   wire logic [4:0]  sleep_code;
   wire logic        sleep_stretch_sel_sel;
   wire logic        limit_stretch_sel_eff;
   wire logic [1:0]  chk_code;
   wire logic [5:0]  lim_min;
   wire logic [17:0] sleep_base;
   wire logic [17:0] nxt_sleep;
   wire logic [3:0]  nxt_chk;
   wire logic [4:0]  bsp_base;
   wire logic [4:0]  nxt_bsp;
   wire logic [9:0]  nxt_minlim;
   wire logic        nxt_ask;

   assign sleep_code = key_sleep_ff[rfc_pkg::SLEEP_MSB:rfc_pkg::SLEEP_LSB];
   assign sleep_stretch_sel_sel = key_sleep_ff[rfc_pkg::SLEEP_STRETCH_SEL_BIT];
   assign chk_code   = chk_lim_ff[rfc_pkg::CHK_MSB:rfc_pkg::CHK_LSB];
   assign lim_min    = chk_lim_ff[rfc_pkg::LIMMIN_MSB:rfc_pkg::LIMMIN_LSB];

   assign nxt_ask    = key_sleep_ff[rfc_pkg::ASK_BIT] && !mode_fd;

   assign sleep_base = {3'h0, sleep_code, 10'h000};
   assign nxt_sleep  = !mode_poll ? 18'h00000 :
                       (sleep_stretch_sel_sel ? (sleep_base << rfc_pkg::SLEEP_STRETCH_SEL_SH) : sleep_base);

   // Stretch only where receive-side limits are in use
   assign limit_stretch_sel_eff   = key_sleep_ff[rfc_pkg::LIMIT_STRETCH_SEL_BIT] && (mode_rx_any || mode_fds);
   assign bsp_base   = rfc_pkg::BSP_RANGE0 >> baud_range;
   assign nxt_bsp    = limit_stretch_sel_eff ? {bsp_base[3:0], 1'b0} : bsp_base;

   // Fields below the least legal minimum are passed on unchecked
   assign nxt_minlim = (mode_rx_any || mode_fds) ? ({4'h0, lim_min} * {5'h00, nxt_bsp}) : 10'h000;

   assign nxt_chk    = (mode_tx || mode_fdm) ? 4'h0 :
                       ({1'b0, chk_code, 1'b0} + {2'h0, chk_code});

   logic        ask_ff;
   logic [17:0] sleep_ff;
   logic [3:0]  chk_ff;
   logic [4:0]  bsp_ff;
   logic [9:0]  minlim_ff;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ask_ff    <= 1'b0;
         sleep_ff  <= 18'h00000;
         chk_ff    <= 4'h0;
         bsp_ff    <= 5'h00;
         minlim_ff <= 10'h000;
      end else begin
         ask_ff    <= nxt_ask;
         sleep_ff  <= nxt_sleep;
         chk_ff    <= nxt_chk;
         bsp_ff    <= nxt_bsp;
         minlim_ff <= nxt_minlim;
      end
   end

   assign amplitude_keying_sel = ask_ff;
   assign sleep_interval       = sleep_ff;
   assign check_bit_count      = chk_ff;
   assign bit_sample_period    = bsp_ff;
   assign min_limit_period     = minlim_ff;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   property p_keying_ignored_fd;
      @(posedge clk) disable iff (!rst_n)
      mode_fd |=> !ask_ff;
   endproperty
   a_keying_ignored_fd: assert property (p_keying_ignored_fd) else $error("ASK active in full duplex");

   property p_sleep_value;
      @(posedge clk) disable iff (!rst_n)
      (mode_poll && !sleep_stretch_sel_sel) |=> sleep_ff == {3'h0, $past(sleep_code), 10'h000};
   endproperty
   a_sleep_value: assert property (p_sleep_value) else $error("sleep interval wrong");

   property p_sleep_stretch;
      @(posedge clk) disable iff (!rst_n)
      (mode_poll && sleep_stretch_sel_sel) |=> sleep_ff == {$past(sleep_code), 13'h0000};
   endproperty
   a_sleep_stretch: assert property (p_sleep_stretch) else $error("sleep stretch wrong");

   property p_check_count;
      @(posedge clk) disable iff (!rst_n)
      (mode_rx_any && chk_code == 2'h3) |=> chk_ff == 4'h9;
   endproperty
   a_check_count: assert property (p_check_count) else $error("check count wrong");

   property p_bsp_stretch;
      @(posedge clk) disable iff (!rst_n)
      (mode_tx && baud_range == 2'h3) |=> bsp_ff == 5'h01;
   endproperty
   a_bsp_stretch: assert property (p_bsp_stretch) else $error("stretch applied in transmit");

   property p_min_limit;
      @(posedge clk) disable iff (!rst_n)
      mode_fds |=> minlim_ff == {4'h0, $past(lim_min)} * {5'h00, bsp_ff};
   endproperty
   a_min_limit: assert property (p_min_limit) else $error("minimum limit wrong");

   property p_readback;
      @(posedge clk) disable iff (!rst_n)
      (wr_key_sleep ##1 !reg_wr_en ##1 (reg_rd_en && !reg_wr_en && reg_addr == rfc_pkg::ADDR_KEY_SLEEP))
      |=> reg_rdata == $past(reg_wdata, 3);
   endproperty
   a_readback: assert property (p_readback) else $error("readback differs from write");
endmodule

// ==== sim/rfc_mcu_model.sv ====
`timescale 1ns/1ps
module rfc_mcu_model (
   input  wire logic       clk,
   output logic            reg_wr_en,
   output logic            reg_rd_en,
   output logic [2:0]      reg_addr,
   output logic [7:0]      reg_wdata,
   input  wire logic [7:0] reg_rdata,
   input  wire logic       reg_rd_hit
);
   // ----------------------------------------
   // Idle bus
   // ----------------------------------------
   initial begin
      reg_wr_en = 1'b0;
      reg_rd_en = 1'b0;
      reg_addr  = 3'h0;
      reg_wdata = 8'h00;
   end

   // ----------------------------------------
   // Register access, driven off the falling edge
   // ----------------------------------------
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      logic [7:0] v;
      v = d;
      if (a == rfc_pkg::ADDR_CHK_LIM && v[5:0] < rfc_pkg::MINLIM_LEAST) begin
         v[5:0] = rfc_pkg::MINLIM_LEAST;
      end
      @(negedge clk);
      reg_addr  = a;
      reg_wdata = v;
      reg_wr_en = 1'b1;
      @(negedge clk);
      reg_wr_en = 1'b0;
      // Released data shows no stale value
      reg_wdata = ~v;
   endtask

   task automatic rd(input logic [2:0] a, output logic [7:0] d, output logic hit);
      @(negedge clk);
      reg_addr  = a;
      reg_rd_en = 1'b1;
      @(negedge clk);
      reg_rd_en = 1'b0;
      d         = reg_rdata;
      hit       = reg_rd_hit;
   endtask
endmodule

// ==== sim/rfc_cfg_regs_tb_top.sv ====
`timescale 1ns/1ps
module rfc_cfg_regs_tb_top;
   logic        clk = 1'b0, rstn = 1'b0, pll_range_sel = 1'b0, bit_check_ok = 1'b0;
   logic        wake_pin_n = 1'b1, wake_status = 1'b0, clk_src_in = 1'b0;
   logic [2:0]  op_mode = rfc_pkg::OPM_IDLE;
   logic [6:0]  lower = 7'h54;
   logic [1:0]  baud_range = 2'h2;
   logic        reg_wr_en, reg_rd_en, reg_rd_hit, clk_out, ask, h;
   logic [2:0]  reg_addr;
   logic [7:0]  reg_wdata, reg_rdata, d;
   logic [12:0] tune;
   logic [17:0] sleep_iv;
   logic [3:0]  chk_cnt;
   logic [4:0]  bsp;
   logic [9:0]  min_lim;
   logic [5:0]  codes [4] = '{6'h00, 6'h07, 6'h38, 6'h3F};
   logic [2:0]  modes [4] = '{rfc_pkg::OPM_TX, rfc_pkg::OPM_RX, rfc_pkg::OPM_FDM, rfc_pkg::OPM_FDS};
   int          error_cnt = 0, compares = 0, cycles = 0, t;

   rfc_mcu_model rfc_mcu_model_inst (.clk(clk), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rd_hit(reg_rd_hit));

   rfc_cfg_regs rfc_cfg_regs_inst (.clk(clk), .rstn(rstn), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rd_hit(reg_rd_hit),
      .pll_range_sel(pll_range_sel), .op_mode(op_mode), .rf_tune_lower_value(lower),
      .baud_range(baud_range), .bit_check_ok(bit_check_ok), .wake_pin_n(wake_pin_n),
      .wake_status(wake_status), .clk_src_in(clk_src_in), .rf_tune_word(tune), .clk_out(clk_out),
      .amplitude_keying_sel(ask), .sleep_interval(sleep_iv), .check_bit_count(chk_cnt),
      .bit_sample_period(bsp), .min_limit_period(min_lim));

   // ----------------------------------------
   // Clock, gated source and hang guard
   // ----------------------------------------
   always #25 clk = ~clk;
   always @(negedge clk) clk_src_in <= ~clk_src_in;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         error_cnt++;
         give_verdict();
      end
   end

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic chk(input string nm, input logic [17:0] exp, input logic [17:0] got);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %0h seen %0h", nm, exp, got);
      end
   endtask

   // Registered outputs need two edges after a write or input change
   task automatic settle;
      repeat (3) @(negedge clk);
   endtask

   task automatic toggles(input int n, output int cnt);
      logic p;
      cnt = 0;
      p = clk_out;
      repeat (n) begin
         @(negedge clk);
         if (clk_out !== p) cnt++;
         p = clk_out;
      end
   endtask

   task automatic give_verdict;
      $display("compares %0d error_cnt %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      repeat (20) @(negedge clk);
      rstn = 1'b1;
      repeat (5) @(negedge clk);
      rfc_mcu_model_inst.rd(3'h2, d, h); chk("reg2_rst", 18'h7B, d);
      chk("hit2", 18'h1, h);
      rfc_mcu_model_inst.rd(3'h3, d, h); chk("reg3_rst", 18'h60, d);
      rfc_mcu_model_inst.rd(3'h4, d, h); chk("reg4_rst", 18'h4B, d);
      chk("tune_rst", 18'h0F54, tune);
      chk("chk_cnt_rst", 18'h3, chk_cnt);
      chk("bsp_rst", 18'h2, bsp);
      toggles(10, t); chk("clk_default_runs", 18'h1, t > 0);
      // Unmapped places answer nothing and keep the bank intact
      rfc_mcu_model_inst.wr(3'h5, 8'hFF);
      rfc_mcu_model_inst.rd(3'h0, d, h); chk("unmapped_data", 18'h0, d);
      chk("unmapped_hit", 18'h0, h);
      rfc_mcu_model_inst.rd(3'h7, d, h); chk("unmapped_hit7", 18'h0, h);
      rfc_mcu_model_inst.rd(3'h4, d, h); chk("reg4_kept", 18'h4B, d);
      // Tuning word in both synthesizer ranges, lower part at both extremes
      for (int r = 0; r < 2; r++) begin
         for (int i = 0; i < 4; i++) begin
            pll_range_sel = r[0];
            lower = i[0] ? 7'h7F : 7'h00;
            rfc_mcu_model_inst.wr(rfc_pkg::ADDR_FREQ_CLK, {codes[i], 2'b11});
            settle();
            chk("tune", r ? 18'({codes[i], 7'h00}) + lower
                          : 18'h0C00 + 18'({codes[i][2:0], 7'h00}) + lower, tune);
         end
      end
      // Clock gating: idle until a wake source, TX bit-check ignored
      for (int k = 0; k < 5; k++) begin
         op_mode = (k == 0) ? rfc_pkg::OPM_TX : ((k == 4) ? rfc_pkg::OPM_RXPOLL : rfc_pkg::OPM_RX);
         rfc_mcu_model_inst.wr(rfc_pkg::ADDR_FREQ_CLK, 8'h7A);
         settle();
         toggles(10, t); chk("clk_held_off", 18'h0, t);
         @(negedge clk);
         bit_check_ok = (k < 2) || (k == 4);
         wake_pin_n = (k != 2);
         wake_status = (k == 3);
         @(negedge clk);
         bit_check_ok = 1'b0;
         wake_pin_n = 1'b1;
         wake_status = 1'b0;
         settle();
         rfc_mcu_model_inst.rd(rfc_pkg::ADDR_FREQ_CLK, d, h); chk("active_flag", 18'(k != 0), d[0]);
         toggles(10, t); chk("clk_runs", 18'(k != 0), t > 0);
      end
      // Software clear and wake status in one cycle: the set must win
      fork
         rfc_mcu_model_inst.wr(rfc_pkg::ADDR_FREQ_CLK, 8'h7A);
         begin
            @(negedge clk);
            wake_status = 1'b1;
            @(negedge clk);
            wake_status = 1'b0;
         end
      join
      settle();
      rfc_mcu_model_inst.rd(rfc_pkg::ADDR_FREQ_CLK, d, h); chk("set_beats_clear", 18'h1, d[0]);
      rfc_mcu_model_inst.wr(rfc_pkg::ADDR_FREQ_CLK, 8'h79);
      wake_status = 1'b1;
      settle();
      toggles(10, t); chk("clk_disabled", 18'h0, t);
      wake_status = 1'b0;
      // Keying select across modes
      rfc_mcu_model_inst.wr(rfc_pkg::ADDR_KEY_SLEEP, 8'h80);
      for (int m = 0; m < 4; m++) begin
         op_mode = modes[m];
         settle();
         chk("ask", 18'(m < 2), ask);
      end
      // Sleep interval with and without stretch, and in TX
      for (int s = 0; s < 2; s++) begin
         rfc_mcu_model_inst.wr(rfc_pkg::ADDR_KEY_SLEEP, {1'b0, 5'h1F, s[0], 1'b0});
         op_mode = rfc_pkg::OPM_RXPOLL;
         settle();
         chk("sleep", s ? 18'd253952 : 18'd31744, sleep_iv);
         op_mode = rfc_pkg::OPM_TX;
         settle();
         chk("sleep_tx", 18'h0, sleep_iv);
      end
      // Sample period and minimum limit for every range and stretch
      rfc_mcu_model_inst.wr(rfc_pkg::ADDR_CHK_LIM, 8'hFF);
      op_mode = rfc_pkg::OPM_RX;
      for (int b = 0; b < 4; b++) begin
         for (int x = 0; x < 2; x++) begin
            rfc_mcu_model_inst.wr(rfc_pkg::ADDR_KEY_SLEEP, {7'h04, x[0]});
            baud_range = b[1:0];
            settle();
            chk("bsp", 18'((8 >> b) * (x + 1)), bsp);
            chk("min_lim", 18'(63 * (8 >> b) * (x + 1)), min_lim);
         end
      end
      // Check count codes, and masking in FD master
      for (int c = 0; c < 4; c++) begin
         rfc_mcu_model_inst.wr(rfc_pkg::ADDR_CHK_LIM, {c[1:0], 6'h0B});
         op_mode = rfc_pkg::OPM_FDS;
         settle();
         chk("chk_cnt", 18'(3 * c), chk_cnt);
         op_mode = rfc_pkg::OPM_FDM;
         settle();
         chk("chk_cnt_fdm", 18'h0, chk_cnt);
      end
      // Stored while unused, effective again on return
      op_mode = rfc_pkg::OPM_TX;
      rfc_mcu_model_inst.wr(rfc_pkg::ADDR_KEY_SLEEP, 8'hA5);
      rfc_mcu_model_inst.rd(rfc_pkg::ADDR_KEY_SLEEP, d, h); chk("reg3_kept", 18'hA5, d);
      op_mode = rfc_pkg::OPM_RXPOLL;
      settle();
      chk("sleep_back", 18'd9216, sleep_iv);
      give_verdict();
   end
endmodule
